// ==== hdl/l2cp_port.sv ====
// Second-level cache port: pin sequencer, capture and read-data FIFO
// How it works
// [R1] Drive 20-bit line index, address bits 23:4, to the cache arrays.
// [R2] Sixteen check bits travel with 128 data bits; made on write, checked on read.
// [R3] Data output enable low while reading the cache.
// [R4] Data write strobe low only while writing cache data.
// [R5] Tag write strobe low only while writing a tag entry.
// [R6] Tag output enable low during cache reads.
// [R7] Free-running differential output clocks, fixed fraction of the core clock.
// [R8] Output clock rising edge lags index change by zero to two cycles.
// [R9] Tag outputs launched in step with the data output clocks.
// [R10] Tag output clock pair copies the data output clocks.
// [R11] Tag and state bits resynchronised to core clock, then captured by returned tag strobe.
// [R12] Read data resynchronised to core clock, then captured per lane by eight data strobes.
// [R13] Dirty bit written set when line data is modified, clear otherwise.
// [R14] Shared bit written one when another agent holds the line.
// [R15] Line counts as hit only with valid bit set.
// [R16] Burst enable low for beats after the first of a transfer.
// [R17] 23-bit tag plus parity bit exchanged on every tag read and write.

module l2cp_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 32
) (
	input  wire logic                     clk,
	input  wire logic                     nrst,
	input  wire logic                     in_valid,
	output logic                          in_ready,
	input  wire logic [W-1:0]             in_data,
	output logic                          out_valid,
	input  wire logic                     out_ready,
	output logic [W-1:0]                  out_data,
	output logic [$clog2(DEPTH):0]        level
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
	logic [AW:0]   cnt_reg, cnt_next;
	logic          push, pop;

	always_comb begin
		push     = in_valid && (cnt_reg != DEPTH[AW:0]);
		pop      = out_ready && (cnt_reg != '0);
		wp_next  = push ? wp_reg + 1'b1 : wp_reg;
		rp_next  = pop ? rp_reg + 1'b1 : rp_reg;
		cnt_next = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wp_reg  <= '0;
			rp_reg  <= '0;
			cnt_reg <= '0;
		end else begin
			wp_reg  <= wp_next;
			rp_reg  <= rp_next;
			cnt_reg <= cnt_next;
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp_reg] <= in_data;
		end
	end

	assign in_ready  = (cnt_reg != DEPTH[AW:0]);
	assign out_valid = (cnt_reg != '0);
	assign out_data  = mem[rp_reg];
	assign level     = cnt_reg;
endmodule : l2cp_fifo

module l2cp_port
	import l2cp_pkg::*;
#(
	parameter int CLK_DIV = L2CP_CLK_DIV,
	parameter int BEATS   = L2CP_BEATS,
	parameter int FDEPTH  = L2CP_FIFO_DEP
) (
	input  wire logic                        clk,
	input  wire logic                        nrst,
	input  wire logic [1:0]                  clk_delay,
	input  wire logic                        req_valid,
	output logic                             req_ready,
	input  wire logic [1:0]                  req_op,
	input  wire logic [L2CP_INDEX_W-1:0]     req_index,
	input  wire logic [L2CP_TAG_W-1:0]       req_tag,
	input  wire logic                        req_line_valid,
	input  wire logic                        req_modified,
	input  wire logic                        req_other_copy,
	input  wire logic [BEATS*L2CP_DATA_W-1:0] req_wdata,
	output logic                             rd_valid,
	input  wire logic                        rd_ready,
	output logic [L2CP_DATA_W-1:0]           rd_data,
	output logic                             rd_ecc_err,
	output logic                             tag_done,
	output logic                             tag_hit,
	output logic [L2CP_TAG_W-1:0]            tag_read,
	output logic                             tag_dirty,
	output logic                             tag_shared,
	output logic                             tag_parity_err,
	output logic [L2CP_INDEX_W-1:0]          cache_index_out,
	output logic [L2CP_DATA_W-1:0]           cache_data_bus_o,
	output logic [L2CP_DATA_W-1:0]           cache_data_bus_oe,
	input  wire logic [L2CP_DATA_W-1:0]      cache_data_bus_i,
	output logic [L2CP_ECC_W-1:0]            cache_ecc_check_o,
	output logic [L2CP_ECC_W-1:0]            cache_ecc_check_oe,
	input  wire logic [L2CP_ECC_W-1:0]       cache_ecc_check_i,
	input  wire logic [L2CP_LANES-1:0]       cache_data_in_strobe,
	output logic                             cache_data_out_enable_n,
	output logic [3:0]                       cache_data_out_clock_p,
	output logic [3:0]                       cache_data_out_clock_n,
	output logic                             cache_data_write_n,
	output logic                             cache_burst_n,
	output logic [L2CP_TAG_W+3:0]            cache_tag_bus_o,
	output logic [L2CP_TAG_W+3:0]            cache_tag_bus_oe,
	input  wire logic [L2CP_TAG_W+3:0]       cache_tag_bus_i,
	input  wire logic                        tag_in_strobe,
	output logic                             tag_out_enable_n,
	output logic                             tag_out_clock_p,
	output logic                             tag_out_clock_n,
	output logic                             tag_write_n
);
	// Tag pin group order: {parity, shared, dirty, valid, tag}
	localparam int PW = $clog2(CLK_DIV);
	localparam int BW = $clog2(BEATS + 1);
	localparam int TGW = L2CP_TAG_W + 4;
	localparam int FW = L2CP_DATA_W + 1;
	localparam logic [PW-1:0] PH_LAST = PW'(CLK_DIV - 1);
	localparam logic [PW-1:0] PH_HALF = PW'(CLK_DIV / 2);
	localparam logic [BW-1:0] BEAT_N = BW'(BEATS);

	function automatic logic [L2CP_ECC_W-1:0] ecc_gen(
		input logic [L2CP_DATA_W-1:0] d
	);
		logic [L2CP_ECC_W-1:0] c;
		c = '0;
		for (int i = 0; i < L2CP_DATA_W; i++) begin
			c[i % L2CP_ECC_W] = c[i % L2CP_ECC_W] ^ d[i];
		end
		return c;
	endfunction : ecc_gen

	function automatic logic [PW-1:0] ph_step(input logic [PW-1:0] p);
		return (p == PH_LAST) ? '0 : p + 1'b1;
	endfunction : ph_step

	// Clock divider and launch slot
	logic [PW-1:0] ph_reg, ph_next, launch_ph;
	logic          clk_reg, clk_next, clkn_reg, clkn_next, slot, pre_slot;

	always_comb begin
		ph_next   = ph_step(ph_reg);
		clk_next  = (ph_next < PH_HALF);                           // [R7]
		launch_ph = (clk_delay == 2'h0 || clk_delay > L2CP_DELAY_MAX) ?
			'0 : PW'(CLK_DIV) - PW'(clk_delay);                    // [R8]
		clkn_next = !clk_next;
		slot      = (ph_next == launch_ph);
		pre_slot  = (ph_step(ph_next) == launch_ph);
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ph_reg  <= PH_LAST;
			clk_reg <= 1'b0;
			clkn_reg <= 1'b1;
		end else begin
			ph_reg  <= ph_next;
			clk_reg <= clk_next;
			clkn_reg <= clkn_next;
		end
	end

	// Input synchronisers, two stages plus an edge stage for strobes
	logic [L2CP_LANES-1:0]  stb_s1, stb_s2, stb_s3;
	logic                   tstb_s1, tstb_s2, tstb_s3;
	logic [L2CP_DATA_W-1:0] dat_s1, dat_s2;
	logic [L2CP_ECC_W-1:0]  ecc_s1, ecc_s2;
	logic [TGW-1:0]         tg_s1, tg_s2;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stb_s1  <= '0;
			stb_s2  <= '0;
			stb_s3  <= '0;
			tstb_s1 <= 1'b0;
			tstb_s2 <= 1'b0;
			tstb_s3 <= 1'b0;
			dat_s1  <= '0;
			dat_s2  <= '0;
			ecc_s1  <= '0;
			ecc_s2  <= '0;
			tg_s1   <= '0;
			tg_s2   <= '0;
		end else begin
			stb_s1  <= cache_data_in_strobe;                       // [R12]
			stb_s2  <= stb_s1;
			stb_s3  <= stb_s2;
			tstb_s1 <= tag_in_strobe;                              // [R11]
			tstb_s2 <= tstb_s1;
			tstb_s3 <= tstb_s2;
			dat_s1  <= cache_data_bus_i;
			dat_s2  <= dat_s1;
			ecc_s1  <= cache_ecc_check_i;
			ecc_s2  <= ecc_s1;
			tg_s1   <= cache_tag_bus_i;
			tg_s2   <= tg_s1;
		end
	end

	// Sequencer
	l2cp_state_type          st_reg, st_next;
	logic [BW-1:0]           beat_reg, beat_next, got_reg, got_next;
	logic [BEATS*L2CP_DATA_W-1:0] wb_reg, wb_next;
	logic [L2CP_TAG_W-1:0]   ctag_reg, ctag_next;
	logic                    tgot_reg, tgot_next, rdy_reg, rdy_next, reading;
	logic [L2CP_INDEX_W-1:0] idx_reg, idx_next;
	logic                    doe_reg, doe_next, dwr_reg, dwr_next;
	logic                    toe_reg, toe_next, twr_reg, twr_next;
	logic                    bst_reg, bst_next, ddrv_reg, ddrv_next;
	logic                    tdrv_reg, tdrv_next;
	logic [L2CP_DATA_W-1:0]  dout_reg, dout_next;
	logic [TGW-1:0]          tout_reg, tout_next;
	logic [L2CP_ECC_W-1:0]   ecc_reg, ecc_next;
	logic                    take, wtag, fifo_in_ready;
	logic [$clog2(FDEPTH):0] fifo_level;

	always_comb begin
		st_next   = st_reg;
		beat_next = beat_reg;
		wb_next   = wb_reg;
		ctag_next = ctag_reg;
		idx_next  = idx_reg;
		doe_next  = doe_reg;
		dwr_next  = dwr_reg;
		toe_next  = toe_reg;
		twr_next  = twr_reg;
		bst_next  = bst_reg;
		ddrv_next = ddrv_reg;
		tdrv_next = tdrv_reg;
		dout_next = dout_reg;
		tout_next = tout_reg;
		take      = req_valid && rdy_reg && slot;
		wtag      = (req_op != L2CP_OP_READ);
		case (st_reg)
		L2CP_IDLE: begin
			if (take) begin
				idx_next  = req_index;                             // [R1]
				beat_next = BW'(1);
				bst_next  = 1'b1;
				ctag_next = req_tag;
				wb_next   = req_wdata;
				if (req_op == L2CP_OP_READ) begin
					doe_next = 1'b0;                               // [R3]
					toe_next = 1'b0;                               // [R6]
					st_next  = L2CP_RD_ISS;
				end else begin
					dwr_next  = (req_op == L2CP_OP_WRITE) ? 1'b0 : 1'b1; // [R4]
					ddrv_next = (req_op == L2CP_OP_WRITE);
					dout_next = req_wdata[L2CP_DATA_W-1:0];
					twr_next  = !wtag;                             // [R5]
					tdrv_next = wtag;
					tout_next = {^{req_tag, req_line_valid, req_modified,
						req_other_copy}, req_other_copy, req_modified,
						req_line_valid, req_tag};           // [R13] [R14] [R17]
					st_next   = L2CP_WR_ISS;
				end
			end
		end
		L2CP_RD_ISS: begin
			if (slot) begin
				if (beat_reg == BEAT_N) begin
					bst_next = 1'b1;
					st_next  = L2CP_RD_WAIT;
				end else begin
					bst_next  = 1'b0;                              // [R16]
					beat_next = beat_reg + 1'b1;
				end
			end
		end
		L2CP_RD_WAIT: begin
			if (slot && got_reg == BEAT_N && tgot_reg) begin
				doe_next = 1'b1;
				toe_next = 1'b1;
				st_next  = L2CP_IDLE;
			end
		end
		L2CP_WR_ISS: begin
			if (slot) begin
				twr_next  = 1'b1;
				tdrv_next = 1'b0;
				if (beat_reg == BEAT_N || dwr_reg) begin
					dwr_next  = 1'b1;
					ddrv_next = 1'b0;
					bst_next  = 1'b1;
					st_next   = L2CP_IDLE;
				end else begin
					bst_next  = 1'b0;                              // [R16]
					dout_next = wb_reg[beat_reg*L2CP_DATA_W +: L2CP_DATA_W];
					beat_next = beat_reg + 1'b1;
				end
			end
		end
		default: begin
			st_next = L2CP_IDLE;
		end
		endcase
		ecc_next = ecc_gen(dout_next);                             // [R2]
		rdy_next = (st_next == L2CP_IDLE) && pre_slot && fifo_in_ready &&
			(fifo_level <= ($clog2(FDEPTH)+1)'(FDEPTH - BEATS));
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_reg   <= L2CP_IDLE;
			beat_reg <= '0;
			wb_reg   <= '0;
			ctag_reg <= '0;
			rdy_reg  <= 1'b0;
			idx_reg  <= '0;
			doe_reg  <= L2CP_OE_OFF;
			dwr_reg  <= 1'b1;
			toe_reg  <= L2CP_OE_OFF;
			twr_reg  <= 1'b1;
			bst_reg  <= 1'b1;
			ddrv_reg <= 1'b0;
			tdrv_reg <= 1'b0;
			dout_reg <= '0;
			ecc_reg  <= '0;
			tout_reg <= '0;
		end else begin
			st_reg   <= st_next;
			beat_reg <= beat_next;
			wb_reg   <= wb_next;
			ctag_reg <= ctag_next;
			rdy_reg  <= rdy_next;
			idx_reg  <= idx_next;
			doe_reg  <= doe_next;
			dwr_reg  <= dwr_next;
			toe_reg  <= toe_next;
			twr_reg  <= twr_next;
			bst_reg  <= bst_next;
			ddrv_reg <= ddrv_next;
			tdrv_reg <= tdrv_next;
			dout_reg <= dout_next;
			ecc_reg  <= ecc_next;
			tout_reg <= tout_next;
		end
	end

	// Read capture per strobe lane, beat pushed when all lanes arrive
	logic [L2CP_LANES-1:0]  mask_reg, mask_next, rise;
	logic [L2CP_DATA_W-1:0] cap_reg, cap_next;
	logic [L2CP_ECC_W-1:0]  ccap_reg, ccap_next;
	logic                   push, tdone_next, tdone_reg;
	logic [FW-1:0]          push_word;
	logic [TGW-1:0]         trd_reg, trd_next;
	logic                   hit_reg, hit_next, perr_reg, perr_next;

	always_comb begin
		reading    = (st_reg == L2CP_RD_ISS) || (st_reg == L2CP_RD_WAIT);
		rise       = stb_s2 & ~stb_s3;
		mask_next  = mask_reg;
		cap_next   = cap_reg;
		ccap_next  = ccap_reg;
		got_next   = take ? '0 : got_reg;
		tgot_next  = take ? 1'b0 : tgot_reg;
		trd_next   = trd_reg;
		hit_next   = hit_reg;
		perr_next  = perr_reg;
		tdone_next = 1'b0;
		push       = 1'b0;
		if (reading) begin
			for (int l = 0; l < L2CP_LANES; l++) begin
				if (rise[l]) begin                                 // [R12]
					cap_next[l*L2CP_LANE_W +: L2CP_LANE_W] =
						dat_s2[l*L2CP_LANE_W +: L2CP_LANE_W];
					ccap_next[l*L2CP_LANE_ECC +: L2CP_LANE_ECC] =
						ecc_s2[l*L2CP_LANE_ECC +: L2CP_LANE_ECC];
				end
			end
			mask_next = mask_reg | rise;
			if (&mask_next && got_reg != BEAT_N) begin
				push      = 1'b1;
				mask_next = '0;
				got_next  = got_reg + 1'b1;
			end
			if (tstb_s2 && !tstb_s3 && !tgot_reg) begin            // [R11]
				trd_next   = tg_s2;
				hit_next   = tg_s2[L2CP_TAG_W] &&
					(tg_s2[L2CP_TAG_W-1:0] == ctag_reg);           // [R15]
				perr_next  = ^tg_s2;                               // [R17]
				tgot_next  = 1'b1;
				tdone_next = 1'b1;
			end
		end else begin
			mask_next = '0;
		end
		push_word = {ecc_gen(cap_next) != ccap_next, cap_next};    // [R2]
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mask_reg  <= '0;
			cap_reg   <= '0;
			ccap_reg  <= '0;
			got_reg   <= '0;
			tgot_reg  <= 1'b0;
			trd_reg   <= '0;
			hit_reg   <= 1'b0;
			perr_reg  <= 1'b0;
			tdone_reg <= 1'b0;
		end else begin
			mask_reg  <= mask_next;
			cap_reg   <= cap_next;
			ccap_reg  <= ccap_next;
			got_reg   <= got_next;
			tgot_reg  <= tgot_next;
			trd_reg   <= trd_next;
			hit_reg   <= hit_next;
			perr_reg  <= perr_next;
			tdone_reg <= tdone_next;
		end
	end

	logic [FW-1:0] pop_word;

	l2cp_fifo #(.W(FW), .DEPTH(FDEPTH)) u_rd_fifo (
		.clk       (clk),
		.nrst      (nrst),
		.in_valid  (push),
		.in_ready  (fifo_in_ready),
		.in_data   (push_word),
		.out_valid (rd_valid),
		.out_ready (rd_ready),
		.out_data  (pop_word),
		.level     (fifo_level)
	);

	assign rd_data    = pop_word[L2CP_DATA_W-1:0];
	assign rd_ecc_err = pop_word[L2CP_DATA_W];

	assign req_ready               = rdy_reg;
	assign tag_done                = tdone_reg;
	assign tag_read                = trd_reg[L2CP_TAG_W-1:0];
	assign tag_hit                 = hit_reg;                      // [R15]
	assign tag_dirty               = trd_reg[L2CP_TAG_W+1];
	assign tag_shared              = trd_reg[L2CP_TAG_W+2];
	assign tag_parity_err          = perr_reg;                     // [R17]
	assign cache_index_out         = idx_reg;
	assign cache_data_bus_o        = dout_reg;
	assign cache_data_bus_oe       = {L2CP_DATA_W{ddrv_reg}};
	assign cache_ecc_check_o       = ecc_reg;                      // [R2]
	assign cache_ecc_check_oe      = {L2CP_ECC_W{ddrv_reg}};
	assign cache_data_out_enable_n = doe_reg;
	assign cache_data_out_clock_p  = {4{clk_reg}};                 // [R7]
	assign cache_data_out_clock_n  = {4{clkn_reg}};
	assign cache_data_write_n      = dwr_reg;
	assign cache_burst_n           = bst_reg;
	assign cache_tag_bus_o         = tout_reg;                     // [R9]
	assign cache_tag_bus_oe        = {TGW{tdrv_reg}};
	assign tag_out_enable_n        = toe_reg;
	assign tag_out_clock_p         = clk_reg;                      // [R10]
	assign tag_out_clock_n         = clkn_reg;
	assign tag_write_n             = twr_reg;
endmodule : l2cp_port

// ==== pkg/l2cp_pkg.sv ====
// Constants and types for the second-level cache port
package l2cp_pkg;
	localparam int L2CP_INDEX_W   = 20;
	localparam int L2CP_DATA_W    = 128;
	localparam int L2CP_ECC_W     = 16;
	localparam int L2CP_TAG_W     = 23;
	localparam int L2CP_LANES     = 8;
	localparam int L2CP_LANE_W    = 16;
	localparam int L2CP_LANE_ECC  = 2;
	localparam int L2CP_CLK_DIV   = 4;
	localparam int L2CP_BEATS     = 2;
	localparam int L2CP_FIFO_DEP  = 32;
	localparam logic [1:0] L2CP_DELAY_MAX = 2'h2;
	localparam logic       L2CP_OE_OFF    = 1'h1;

	typedef enum logic [1:0] {
		L2CP_OP_READ  = 2'h0,
		L2CP_OP_WRITE = 2'h1,
		L2CP_OP_TAGWR = 2'h2
	} l2cp_op_type;

	typedef enum logic [3:0] {
		L2CP_IDLE    = 4'h1,
		L2CP_RD_ISS  = 4'h2,
		L2CP_RD_WAIT = 4'h4,
		L2CP_WR_ISS  = 4'h8
	} l2cp_state_type;
endpackage : l2cp_pkg

// ==== bench/l2cp_checker.sv ====
// Pin-level assertions for the second-level cache port
module l2cp_checker
	import l2cp_pkg::*;
#(
	parameter int CLK_DIV = 4
) (
	input wire logic				clk,
	input wire logic				nrst,
	input wire logic [1:0]			clk_delay,
	input wire logic				req_valid,
	input wire logic				req_ready,
	input wire logic [1:0]			req_op,
	input wire logic [L2CP_INDEX_W-1:0]	req_index,
	input wire logic [L2CP_INDEX_W-1:0]	cache_index_out,
	input wire logic [L2CP_DATA_W-1:0]	cache_data_bus_oe,
	input wire logic				cache_data_out_enable_n,
	input wire logic [3:0]			cache_data_out_clock_p,
	input wire logic [3:0]			cache_data_out_clock_n,
	input wire logic				cache_data_write_n,
	input wire logic				cache_burst_n,
	input wire logic [L2CP_TAG_W+3:0]	cache_tag_bus_o,
	input wire logic [L2CP_TAG_W+3:0]	cache_tag_bus_oe,
	input wire logic				tag_out_enable_n,
	input wire logic				tag_out_clock_p,
	input wire logic				tag_write_n
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!nrst);

	index_take_a: assert property (req_valid && req_ready
		|=> cache_index_out == $past(req_index)) else $error("index lost");
	read_oe_a: assert property (!cache_data_out_enable_n
		|-> cache_data_bus_oe == '0 && cache_data_write_n) else $error("rd oe");
	data_wr_a: assert property (!cache_data_write_n
		|-> &cache_data_bus_oe && cache_data_out_enable_n) else $error("wr");
	tag_wr_a: assert property (!tag_write_n
		|-> &cache_tag_bus_oe && !(^cache_tag_bus_o)) else $error("tag wr");
	tag_rd_a: assert property (!tag_out_enable_n
		|-> cache_tag_bus_oe == '0 && tag_write_n) else $error("tag rd");
	clk_period_a: assert property ($rose(cache_data_out_clock_p[0])
		|-> ##CLK_DIV $rose(cache_data_out_clock_p[0])) else $error("period");
	clk_diff_a: assert property (1'h1
		|-> cache_data_out_clock_n == ~cache_data_out_clock_p) else $error("dif");
	tag_echo_a: assert property (1'h1
		|-> tag_out_clock_p == cache_data_out_clock_p[0]) else $error("echo");
	launch_zero_a: assert property (req_valid && req_ready && clk_delay == 2'h0
		|=> $rose(cache_data_out_clock_p[0])) else $error("lag 0");
	launch_two_a: assert property (req_valid && req_ready && clk_delay == 2'h2
		|=> ##2 $rose(cache_data_out_clock_p[0])) else $error("lag 2");
	launch_one_a: assert property (req_valid && req_ready && clk_delay == 2'h1
		|=> ##1 $rose(cache_data_out_clock_p[0])) else $error("lag 1");
	burst_beat_a: assert property (req_valid && req_ready && req_op != 2'h2
		|=> cache_burst_n ##CLK_DIV !cache_burst_n) else $error("burst");
endmodule : l2cp_checker

bind l2cp_port l2cp_checker #(.CLK_DIV(CLK_DIV)) l2cp_checker_i (.*);

// ==== bench/l2cp_ram_model.sv ====
// Behavioural cache data and tag RAM arrays on the far side of the port
module l2cp_ram_model (
	input wire logic [3:0]		cache_data_out_clock_p,
	input wire logic [19:0]		cache_index_out,
	input wire logic			cache_data_out_enable_n,
	input wire logic			cache_data_write_n,
	input wire logic			tag_write_n,
	input wire logic			cache_burst_n,
	input wire logic [127:0]	cache_data_bus_o,
	input wire logic [15:0]		cache_ecc_check_o,
	input wire logic [26:0]		cache_tag_bus_o,
	input wire logic			slow,
	input wire logic			bad,
	output logic [127:0]		md_d,
	output logic [15:0]			md_e,
	output logic [26:0]			md_t,
	output logic [7:0]			cache_data_in_strobe,
	output logic				tag_in_strobe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [143:0]	dmem [int];
	logic [26:0]	tmem [int];
	logic [143:0]	w;
	int				k;

	initial begin
		{md_e, md_d} = 144'h0;
		md_t = 27'h0;
		cache_data_in_strobe = 8'h0;
		tag_in_strobe = 1'h0;
	end

	// Samples what the port launched for this output clock period
	always @(posedge cache_data_out_clock_p[0]) begin
		#1;
		k = cache_index_out * 2 + !cache_burst_n;
		if (!cache_data_write_n) begin
			dmem[k] = {cache_ecc_check_o, cache_data_bus_o};
		end
		if (!tag_write_n) begin
			tmem[cache_index_out] = cache_tag_bus_o;
		end
		if (!cache_data_out_enable_n && cache_burst_n) begin
			#(slow ? 200 : 20);
			md_t = tmem.exists(k / 2) ? tmem[k / 2] : 27'h0;
			for (int b = 0; b < 2; b++) begin
				w = dmem.exists(k + b) ? dmem[k + b] : 144'h0;
				{md_e, md_d} = w ^ {15'h0, bad, 128'h0};
				#60;
				cache_data_in_strobe = 8'hFF;
				tag_in_strobe = (b == 0);
				#80;
				cache_data_in_strobe = 8'h0;
				tag_in_strobe = 1'h0;
				#20;
			end
			// Released buses show no stale value
			{md_e, md_d} = ~w;
			md_t = ~md_t;
			wait (cache_data_out_enable_n);
		end
	end
endmodule : l2cp_ram_model

// ==== bench/l2cp_port_test.sv ====
// Self-checking bench for the second-level cache port
module l2cp_port_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'h0;
	logic nrst, req_valid, req_ready, req_line_valid, req_modified, slow, bad;
	logic req_other_copy, rd_valid, rd_ready, rd_ecc_err, tag_done, tag_hit;
	logic tag_dirty, tag_shared, tag_parity_err, cache_data_out_enable_n;
	logic cache_data_write_n, cache_burst_n, tag_in_strobe, tag_out_enable_n;
	logic tag_out_clock_p, tag_out_clock_n, tag_write_n;
	logic [1:0]		clk_delay, req_op;
	logic [3:0]		cache_data_out_clock_p, cache_data_out_clock_n;
	logic [7:0]		cache_data_in_strobe;
	logic [15:0]	cache_ecc_check_o, cache_ecc_check_oe, cache_ecc_check_i, md_e;
	logic [19:0]	req_index, cache_index_out;
	logic [22:0]	req_tag, tag_read;
	logic [26:0]	cache_tag_bus_o, cache_tag_bus_oe, cache_tag_bus_i, md_t;
	logic [127:0]	rd_data, cache_data_bus_o, cache_data_bus_oe;
	logic [127:0]	cache_data_bus_i, md_d;
	logic [255:0]	req_wdata;
	int				bad_count = 0;
	int				cmp_count = 0;

	assign cache_data_bus_i = cache_data_bus_o & cache_data_bus_oe
		| md_d & ~cache_data_bus_oe;
	assign cache_ecc_check_i = cache_ecc_check_o & cache_ecc_check_oe
		| md_e & ~cache_ecc_check_oe;
	assign cache_tag_bus_i = cache_tag_bus_o & cache_tag_bus_oe
		| md_t & ~cache_tag_bus_oe;

	l2cp_port l2cp_port_i (.*);
	l2cp_ram_model l2cp_ram_model_i (.*);

	always #10 clk = ~clk;

	task automatic check(input logic [127:0] got, input logic [127:0] want);
		cmp_count++;
		if (got !== want) begin
			bad_count++;
			$display("[FAIL] %0t got %h want %h", $time, got, want);
		end
	endtask : check

	function automatic logic [127:0] pat(input int i, input int b);
		return {4{8'(i), 8'(b), 16'hC35A}};
	endfunction : pat

	function automatic logic [2:0] stf(input int i);
		return {i != 5, i[0], i[2]};
	endfunction : stf

	// Holds the request until a taking edge, called at a falling edge
	task automatic req(input logic [1:0] op, input int i, input logic [2:0] st);
		int n;
		n = 0;
		@(negedge clk);
		req_valid = 1'h1;
		req_op = op;
		req_index = 20'(i);
		req_tag = 23'(i * 77 + 9);
		{req_line_valid, req_modified, req_other_copy} = st;
		req_wdata = {pat(i, 1), pat(i, 0)} ^ {256{op[1]}};
		// Ready seen settled at a falling edge: the next rising edge takes
		while (req_ready !== 1'h1 && n < 99) begin
			@(negedge clk);
			n++;
		end
		@(negedge clk);
		req_valid = 1'h0;
		check(n < 99, 1'h1);
	endtask : req

	task automatic pop(input int i, input int b);
		int n;
		n = 0;
		@(negedge clk);
		while (rd_valid !== 1'h1 && n < 200) begin
			@(negedge clk);
			n++;
		end
		check(n < 200, 1'h1);
		check(rd_data, pat(i, b));
		check(rd_ecc_err, bad);
		rd_ready = 1'h1;
		@(negedge clk);
		rd_ready = 1'h0;
	endtask : pop

	task automatic tagchk(input int i, input logic [2:0] st);
		check(tag_read, 23'(i * 77 + 9));
		check(tag_hit, st[2]);
		check(tag_dirty, st[1]);
		check(tag_shared, st[0]);
		check(tag_parity_err, 1'h0);
	endtask : tagchk

	task automatic finish_test();
		$display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : finish_test

	initial begin
		#200000;
		bad_count++;
		finish_test();
	end

	initial begin
		{nrst, req_valid, req_line_valid, req_modified, req_other_copy} = 5'h0;
		{rd_ready, slow, bad, req_op, clk_delay} = 7'h2;
		req_index = 20'h0;
		req_tag = 23'h0;
		req_wdata = 256'h0;
		repeat (16) @(negedge clk);
		nrst = 1'h1;
		for (int i = 0; i < 16; i++) begin
			req(2'h1, i, stf(i));
		end
		req(2'h2, 3, 3'h5);
		while (req_ready !== 1'h1) @(negedge clk);
		clk_delay = 2'h0;
		// Fill the read buffer, alternating prompt and slow memory
		for (int i = 0; i < 16; i++) begin
			slow = i[0];
			req(2'h0, i, 3'h0);
			while (tag_done !== 1'h1) @(negedge clk);
			tagchk(i, i == 3 ? 3'h5 : stf(i));
		end
		req_valid = 1'h1;
		repeat (40) begin
			@(negedge clk);
			check(req_ready, 1'h0);
		end
		req_valid = 1'h0;
		for (int i = 0; i < 32; i++) begin
			pop(i / 2, i % 2);
		end
		check(rd_valid, 1'h0);
		// Corrupted check bits on a one-cycle lag launch
		bad = 1'h1;
		clk_delay = 2'h1;
		req(2'h0, 9, 3'h0);
		pop(9, 0);
		pop(9, 1);
		finish_test();
	end
endmodule : l2cp_port_test
